// ---- hw/bmps_defs.svh ----
/*
 memory, protection, boot and supply supervision constants.
 assumes nothing; include by bare name.
*/
`ifndef BMPS_DEFS_SVH
`define BMPS_DEFS_SVH
`define SRAM_WORDS       1024
`define SRAM_AW          10
`define FLASH_BYTES      32768
`define REGION_BYTES     4096
`define NUM_REGIONS      8
`define ALIAS_BOOT_BASE  32'h0000_0000
`define ALIAS_NATIVE_BASE 32'h0800_0000
`define FLASH_AW         15
`define RDP_LEVEL0       2'h0
`define RDP_LEVEL1       2'h1
`define RDP_LEVEL2       2'h2
`define BOOT_FLASH       2'h0
`define BOOT_SYSMEM      2'h1
`define BOOT_SRAM        2'h2
`endif

// ---- hw/bmps_pkg.sv ----
/*
 types for the boot memory protection supervisor.
 assumes the defs header for figures.
*/
package bmps_pkg;
   typedef enum logic [1:0] {
      boot_flash,
      boot_sysmem,
      boot_sram
   } boot_src_t;
   typedef struct packed {
      logic [1:0] rdp_level;
      logic [7:0] wrp_n;
      logic       boot_sel;
      logic       analog_sup_off;
   } option_t;
   typedef struct packed {
      logic        req;
      logic        we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } mem_req_t;
   typedef enum logic [1:0] {
      st_reset,
      st_run
   } sup_state_t;
endpackage

// ---- hw/boot_memory_protection_supervisor.sv ----
/*
 boot memory protection supervisor: zero wait sram with parity, flash gate
 with region write protect and readout levels, boot select, flash alias,
 supply reset holding and threshold detector events.
 assumes comparator levels and flash array outside, synchronous to mclk.
*/
// Operation
// - sram of 4 Kbytes answers every access with zero wait states
// - sram parity checked on reads; failure raises exception to cpu
// - 32 Kbyte program array and separate option byte area
// - option bytes write protect each 4 KB flash region independently
// - level zero places no restriction on program memory access
// - level one blocks flash access with debugger or ram boot
// - level two kills debug and refuses ram boot
// - boot pin and option bit choose flash, system memory or sram
// - system memory loader reprograms flash from serial host image
// - flash seen identically at boot base and native base
// - reset supervisors always active, hold reset while supply low; with analog watch on, analog low alone toggles hold_reset every cycle
// - power-on release depends only on digital supply
// - power-down watches both supplies; option bit drops analog watch
// - threshold detector events on falling, rising or both edges
// - threshold detector idle until software enables it
`timescale 1ns/1ps
`include "bmps_defs.svh"
module boot_memory_protection_supervisor (
   input  wire logic              mclk,
   input  wire logic              resetn,
   input  wire bmps_pkg::option_t option_bytes,
   input  wire logic              boot_select_pin,
   input  wire logic              debug_attached,
   input  wire logic              digital_supply_ok,
   input  wire logic              analog_supply_ok,
   input  wire bmps_pkg::mem_req_t sram_req,
   input  wire bmps_pkg::mem_req_t flash_req,
   input  wire logic [31:0]       flash_rdata,
   input  wire logic              std_en,
   input  wire logic              std_rise_en,
   input  wire logic              std_fall_en,
   input  wire logic              supply_below_threshold,
   output logic [31:0]            sram_rdata,
   output logic                   sram_ack,
   output logic                   parity_exception,
   output logic                   flash_re,
   output logic                   flash_we,
   output logic [14:0]            flash_addr,
   output logic [31:0]            flash_wdata,
   output logic [31:0]            flash_data_out,
   output logic                   flash_ack,
   output logic                   flash_refused,
   output logic                   debug_enable,
   output logic [1:0]             boot_source,
   output logic                   hold_reset,
   output logic                   std_event
);
   // parity over a word
   function automatic logic par(input logic [31:0] w);
      par = ^w;
   endfunction

   // window test against one alias base
   function automatic logic in_flash(input logic [31:0] a, input logic [31:0] base);
      in_flash = (a >= base) && (a < base + 32'(`FLASH_BYTES));
   endfunction

   // option latch and boot choice
   bmps_pkg::option_t opt_q, opt_d;
   logic [1:0]        boot_q, boot_d;
   logic              dbg_q, dbg_d;
   // sram
   logic [32:0]       mem_q [`SRAM_WORDS];
   logic [31:0]       srd_q, srd_d;
   logic              sack_q, sack_d, perr_q, perr_d;
   // flash gate
   logic              fre_q, fre_d, fwe_q, fwe_d, fack_q, fack_d, fref_q, fref_d;
   logic [14:0]       fadr_q, fadr_d;
   logic [31:0]       fwd_q, fwd_d, fdo_q, fdo_d;
   // supervisor
   bmps_pkg::sup_state_t st_q, st_d;
   logic              hold_q, hold_d, below_q, below_d, sev_q, sev_d;
   logic [`SRAM_AW-1:0] sidx;
   logic              fhit, blocked, wr_locked;
   logic [2:0]        region;

   assign sidx = sram_req.addr[`SRAM_AW+1:2];

   always_comb begin
      opt_d  = opt_q;
      boot_d = boot_q;
      dbg_d  = dbg_q;
      if (!resetn || hold_q) begin
         opt_d = option_bytes;
         if (!boot_select_pin)
            boot_d = `BOOT_FLASH;
         else if (option_bytes.boot_sel)
            boot_d = `BOOT_SYSMEM;
         // ram boot refused at level two
         else if (option_bytes.rdp_level == `RDP_LEVEL2)
            boot_d = `BOOT_FLASH;
         else
            boot_d = `BOOT_SRAM;
         dbg_d = (option_bytes.rdp_level != `RDP_LEVEL2);
      end
   end

   always_ff @(posedge mclk) begin
      opt_q  <= opt_d;
      boot_q <= boot_d;
      dbg_q  <= dbg_d;
   end

   always_comb begin
      srd_d  = 32'h0000_0000;
      sack_d = 1'b0;
      perr_d = 1'b0;
      if (sram_req.req && !hold_q) begin
         sack_d = 1'b1;
         if (!sram_req.we) begin
            srd_d = mem_q[sidx][31:0];
            perr_d = (par(mem_q[sidx][31:0]) != mem_q[sidx][32]);
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sram_req.req && sram_req.we && !hold_q)
         mem_q[sidx] <= {par(sram_req.wdata), sram_req.wdata};
      if (!resetn) begin
         srd_q  <= 32'h0000_0000;
         sack_q <= 1'b0;
         perr_q <= 1'b0;
      end else begin
         srd_q  <= srd_d;
         sack_q <= sack_d;
         perr_q <= perr_d;
      end
   end

   // both alias windows decode to the same array
   assign fhit = in_flash(flash_req.addr, `ALIAS_BOOT_BASE)
              || in_flash(flash_req.addr, `ALIAS_NATIVE_BASE);
   assign region = flash_req.addr[14:12];
   assign blocked = (opt_q.rdp_level != `RDP_LEVEL0)
                 && (debug_attached || boot_q == `BOOT_SRAM);
   // region write protect, active low bit
   assign wr_locked = !opt_q.wrp_n[region];

   always_comb begin
      fre_d  = 1'b0;
      fwe_d  = 1'b0;
      fack_d = 1'b0;
      fref_d = 1'b0;
      fadr_d = fadr_q;
      fwd_d  = fwd_q;
      fdo_d  = 32'h0000_0000;
      // program array only; option area arrives on its own port
      if (flash_req.req && fhit && !hold_q) begin
         fack_d = 1'b1;
         fadr_d = flash_req.addr[`FLASH_AW-1:0];
         fwd_d  = flash_req.wdata;
         // loader writes take the same protected path
         if (blocked || (flash_req.we && wr_locked))
            fref_d = 1'b1;
         else if (flash_req.we)
            fwe_d = 1'b1;
         else begin
            fre_d = 1'b1;
            fdo_d = flash_rdata;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         fre_q  <= 1'b0;
         fwe_q  <= 1'b0;
         fack_q <= 1'b0;
         fref_q <= 1'b0;
         fadr_q <= 15'h0000;
         fwd_q  <= 32'h0000_0000;
         fdo_q  <= 32'h0000_0000;
      end else begin
         fre_q  <= fre_d;
         fwe_q  <= fwe_d;
         fack_q <= fack_d;
         fref_q <= fref_d;
         fadr_q <= fadr_d;
         fwd_q  <= fwd_d;
         fdo_q  <= fdo_d;
      end
   end

   always_comb begin
      st_d    = st_q;
      hold_d  = hold_q;
      sev_d   = 1'b0;
      below_d = below_q;
      case (st_q)
         bmps_pkg::st_reset: begin
            hold_d = 1'b1;
            if (digital_supply_ok) begin
               st_d   = bmps_pkg::st_run;
               hold_d = 1'b0;
            end
         end
         bmps_pkg::st_run: begin
            if (!digital_supply_ok || (!analog_supply_ok && !opt_q.analog_sup_off)) begin
               st_d   = bmps_pkg::st_reset;
               hold_d = 1'b1;
            end
         end
         default: begin
            st_d   = bmps_pkg::st_reset;
            hold_d = 1'b1;
         end
      endcase
      if (std_en) begin
         below_d = supply_below_threshold;
         sev_d   = (std_fall_en && supply_below_threshold && !below_q)
                || (std_rise_en && !supply_below_threshold && below_q);
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         st_q    <= bmps_pkg::st_reset;
         hold_q  <= 1'b1;
         below_q <= 1'b0;
         sev_q   <= 1'b0;
      end else begin
         st_q    <= st_d;
         hold_q  <= hold_d;
         below_q <= below_d;
         sev_q   <= sev_d;
      end
   end

   assign sram_rdata       = srd_q;
   assign sram_ack         = sack_q;
   assign parity_exception = perr_q;
   assign flash_re         = fre_q;
   assign flash_we         = fwe_q;
   assign flash_addr       = fadr_q;
   assign flash_wdata      = fwd_q;
   assign flash_data_out   = fdo_q;
   assign flash_ack        = fack_q;
   assign flash_refused    = fref_q;
   assign debug_enable     = dbg_q;
   assign boot_source      = boot_q;
   assign hold_reset       = hold_q;
   assign std_event        = sev_q;

   a_sram_zero_wait: assert property (@(posedge mclk) disable iff (!resetn)
      sram_req.req && !hold_q |=> sram_ack) else $error("sram ack late");
   a_parity_flag: assert property (@(posedge mclk) disable iff (!resetn)
      parity_exception |-> sram_ack) else $error("parity without access");
   a_region_lock: assert property (@(posedge mclk) disable iff (!resetn)
      flash_req.req && fhit && !hold_q && flash_req.we && wr_locked |=> !flash_we && flash_refused)
      else $error("locked region written");
   a_level0_open: assert property (@(posedge mclk) disable iff (!resetn)
      flash_req.req && fhit && !hold_q && !flash_req.we && opt_q.rdp_level == `RDP_LEVEL0
      |=> flash_re) else $error("level0 read refused");
   a_level1_block: assert property (@(posedge mclk) disable iff (!resetn)
      flash_req.req && fhit && opt_q.rdp_level == `RDP_LEVEL1 && debug_attached
      |=> !flash_re && !flash_we) else $error("level1 access passed");
   a_level2_nodbg: assert property (@(posedge mclk) disable iff (!resetn)
      !hold_q && opt_q.rdp_level == `RDP_LEVEL2 |-> !debug_enable && boot_source != `BOOT_SRAM)
      else $error("level2 debug or ram boot");
   a_opt_stable: assert property (@(posedge mclk) disable iff (!resetn)
      !hold_q && !$past(hold_q) |-> $stable(opt_q)) else $error("options changed in run");
   a_pdr_analog: assert property (@(posedge mclk) disable iff (!resetn)
      st_q == bmps_pkg::st_run && !analog_supply_ok && !opt_q.analog_sup_off |=> hold_reset)
      else $error("analog drop missed");
   a_std_idle: assert property (@(posedge mclk) disable iff (!resetn)
      !std_en |=> !std_event) else $error("detector event while off");
   a_boot_sysmem: assert property (@(posedge mclk) disable iff (!resetn)
      hold_reset && boot_select_pin && option_bytes.boot_sel |=> boot_source == `BOOT_SYSMEM)
      else $error("boot decode wrong");
   a_alias_native: assert property (@(posedge mclk) disable iff (!resetn)
      flash_req.req && !hold_q && (flash_req.addr >> `FLASH_AW) == (`ALIAS_NATIVE_BASE >> `FLASH_AW)
      |=> flash_ack) else $error("native alias not answered");
   a_por_release: assert property (@(posedge mclk) disable iff (!resetn)
      st_q == bmps_pkg::st_reset && digital_supply_ok |=> !hold_reset)
      else $error("release not on digital supply");
   a_std_fall: assert property (@(posedge mclk) disable iff (!resetn)
      std_en && std_fall_en && supply_below_threshold && !below_q |=> std_event)
      else $error("falling event missed");

   c_parity_hit: cover property (@(posedge mclk) disable iff (!resetn) parity_exception);
   c_refused: cover property (@(posedge mclk) disable iff (!resetn) flash_refused);
   c_std_event: cover property (@(posedge mclk) disable iff (!resetn) std_event);
   c_reset_drop: cover property (@(posedge mclk) disable iff (!resetn)
      !hold_reset ##1 hold_reset);
endmodule

// ---- testbench/flash_array_model.sv ----
/*
 flash array model behind the supervisor's flash port.
 assumes write pulses synchronous to mclk.
*/
`timescale 1ns/1ps
module flash_array_model (
   input  wire logic        mclk,
   input  wire logic [31:0] req_addr,
   input  wire logic        flash_we,
   input  wire logic [14:0] flash_addr,
   input  wire logic [31:0] flash_wdata,
   output logic [31:0]      flash_rdata
);
   logic [31:0] mem [8192];
   initial begin
      for (int k = 0; k < 8192; k++) mem[k] = {19'h2a5a5, 13'(k)};
   end
   // one 32 KB array, offset only
   assign flash_rdata = mem[req_addr[14:2]];
   always @(posedge mclk) begin
      if (flash_we) mem[flash_addr[14:2]] <= flash_wdata;
   end
endmodule

// ---- testbench/boot_memory_protection_supervisor_bench.sv ----
/*
 self-checking bench for the boot memory protection supervisor.
 assumes the flash array model and the defs header on the include path.
*/
`timescale 1ns/1ps
`include "bmps_defs.svh"
module boot_memory_protection_supervisor_bench;
   logic               mclk, resetn, boot_select_pin, debug_attached, digital_supply_ok;
   logic               analog_supply_ok, supply_below_threshold, std_en, std_rise_en;
   logic               std_fall_en, sram_ack, parity_exception, flash_re, flash_we;
   logic               flash_ack, flash_refused, debug_enable, hold_reset, std_event;
   logic [1:0]         boot_source;
   logic [14:0]        flash_addr;
   logic [31:0]        flash_rdata, sram_rdata, flash_wdata, flash_data_out, a, w;
   logic [7:0]         wp;
   logic [4:0]         tbl [8];
   bmps_pkg::option_t  option_bytes;
   bmps_pkg::mem_req_t sram_req, flash_req;
   int                 seed, bad_count, cmp_count, cyc, i, n;

   boot_memory_protection_supervisor i_boot_memory_protection_supervisor (
      .mclk, .resetn, .option_bytes, .boot_select_pin, .debug_attached, .digital_supply_ok,
      .analog_supply_ok, .sram_req, .flash_req, .flash_rdata, .std_en, .std_rise_en,
      .std_fall_en, .supply_below_threshold, .sram_rdata, .sram_ack, .parity_exception,
      .flash_re, .flash_we, .flash_addr, .flash_wdata, .flash_data_out, .flash_ack,
      .flash_refused, .debug_enable, .boot_source, .hold_reset, .std_event);
   flash_array_model i_flash_array_model (
      .mclk, .req_addr(flash_req.addr), .flash_we, .flash_addr, .flash_wdata, .flash_rdata);

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   function automatic logic [31:0] exp_word(input logic [31:0] ad);
      return {19'h2a5a5, ad[14:2]};
   endfunction

   task automatic final_report;
      if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] got);
      cmp_count++;
      if (got !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, got);
         bad_count++;
      end
   endtask

   task automatic run_wait;
      int k;
      for (k = 0; k < 8 && hold_reset !== 1'b0; k++) begin
         @(posedge mclk);
         #1;
      end
      chk("release", 1, k < 8);
   endtask

   task automatic rst(input logic [1:0] lv, input logic [7:0] p, input logic sel, off, pin);
      @(posedge mclk);
      resetn <= 1'b0;
      option_bytes <= {lv, p, sel, off};
      boot_select_pin <= pin;
      repeat (6) @(posedge mclk);
      chk("hold_in_reset", 1, hold_reset);
      resetn <= 1'b1;
      run_wait;
   endtask

   task automatic sop(input logic we, input logic [31:0] ad, d);
      @(posedge mclk);
      sram_req <= '{1'b1, we, ad, d};
      @(posedge mclk);
      sram_req <= '0;
      #1;
      chk("sram_ack", 1, sram_ack);
      if (!we) chk("sram_rdata", d, sram_rdata);
      chk("parity", 0, parity_exception);
   endtask

   task automatic fop(input logic dbg, we, input logic [31:0] ad, d, input logic [2:0] k);
      @(posedge mclk);
      debug_attached <= dbg;
      flash_req <= '{1'b1, we, ad, d};
      @(posedge mclk);
      flash_req <= '0;
      #1;
      chk("flash_ack", 1, flash_ack);
      chk("flash_kind", k, {flash_re, flash_we, flash_refused});
      if (k == 3'b100) chk("flash_data", exp_word(ad), flash_data_out);
      if (k == 3'b010) chk("flash_addr", {17'h0, ad[14:0]}, {17'h0, flash_addr});
      if (k == 3'b010) chk("flash_wdata", d, flash_wdata);
   endtask

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         final_report;
      end
   end

   initial begin
      seed = 32'he09d4c34;
      {resetn, boot_select_pin, debug_attached, std_en, std_rise_en, std_fall_en} = '0;
      {digital_supply_ok, analog_supply_ok, supply_below_threshold} = 3'b110;
      option_bytes = '0;
      sram_req = '0;
      flash_req = '0;
      {bad_count, cmp_count, cyc} = '0;
      wp = $random(seed);
      rst(2'h0, wp, 1'b1, 1'b0, 1'b0);
      chk("boot", `BOOT_FLASH, boot_source);
      option_bytes <= {2'h2, 8'h00, 2'b00};
      for (i = 0; i < 16; i++) begin
         a = (i == 0) ? 32'hffc : ($random(seed) & 32'hffc);
         w = $random(seed);
         sop(1'b1, a, w);
         sop(1'b0, a, w);
      end
      chk("debug_held", 1, debug_enable);
      for (i = 0; i < 8; i++) begin
         a = $random(seed) & 32'h6ffc;
         fop(1'b1, 1'b0, a, 0, 3'b100);
         fop(1'b0, 1'b0, a | `ALIAS_NATIVE_BASE, 0, 3'b100);
         a = {17'h0, i[2:0], 12'hffc};
         fop(1'b0, 1'b1, a, exp_word(a), wp[i] ? 3'b010 : 3'b001);
      end
      @(posedge mclk);
      flash_req <= '{1'b1, 1'b0, 32'h0001_0000, 32'h0};
      @(posedge mclk);
      flash_req <= '0;
      #1;
      chk("flash_window", 0, flash_ack);
      rst(2'h1, 8'hff, 1'b1, 1'b0, 1'b0);
      fop(1'b1, 1'b0, 32'h100, 0, 3'b001);
      fop(1'b1, 1'b1, 32'h100, 0, 3'b001);
      fop(1'b0, 1'b0, 32'h100, 0, 3'b100);
      rst(2'h1, 8'hff, 1'b0, 1'b0, 1'b1);
      chk("boot", `BOOT_SRAM, boot_source);
      fop(1'b0, 1'b0, 32'h100, 0, 3'b001);
      rst(2'h0, 8'hff, 1'b1, 1'b0, 1'b1);
      chk("boot", `BOOT_SYSMEM, boot_source);
      rst(2'h2, 8'hff, 1'b0, 1'b0, 1'b1);
      chk("boot", `BOOT_FLASH, boot_source);
      chk("debug_en", 0, debug_enable);
      @(posedge mclk) digital_supply_ok <= 1'b0;
      repeat (2) @(posedge mclk);
      chk("hold_dig", 1, hold_reset);
      digital_supply_ok <= 1'b1;
      run_wait;
      @(posedge mclk) analog_supply_ok <= 1'b0;
      repeat (2) @(posedge mclk);
      chk("hold_ana", 1, hold_reset);
      analog_supply_ok <= 1'b1;
      run_wait;
      analog_supply_ok <= 1'b0;
      rst(2'h0, 8'hff, 1'b1, 1'b1, 1'b0);
      repeat (3) @(posedge mclk);
      chk("ana_off", 0, hold_reset);
      analog_supply_ok <= 1'b1;
      tbl = '{5'b01110, 5'b01100, 5'b10111, 5'b10100, 5'b11010, 5'b11001, 5'b11111,
              5'b11101};
      for (i = 0; i < 8; i++) begin
         @(posedge mclk);
         {std_en, std_rise_en, std_fall_en, supply_below_threshold} <= tbl[i][4:1];
         n = 0;
         repeat (4) begin
            @(posedge mclk);
            #1;
            n += (std_event !== 1'b0);
         end
         chk("std_event", tbl[i][0], n);
      end
      final_report;
   end
endmodule
